// [rtl/safety_clock_selftest_status.sv]
`timescale 1ns/100ps
`default_nettype none

module safety_clock_selftest_status (
  input wire logic clk, // 20 MHz clock
  input wire logic resetn, // Synchronous reset, active low
  input wire status_bank_pkg::clock_warn_t clk_warn_in, // Monitor levels
  input wire status_bank_pkg::group_result_t group_in, // Self-test levels
  input wire status_bank_pkg::uv_result_t uv_in, // UV test levels
  input wire status_bank_pkg::read_req_t rd_req, // Read strobe and select
  input wire logic wr_strobe, // Write attempt, ignored
  output logic [7:0] rd_data, // Read data, registered
  output logic rd_valid, // Read data valid pulse
  output logic [7:0] clock_accuracy_warning_status, // Live register view
  output logic [7:0] selftest_group_status, // Live register view
  output logic [7:0] selftest_undervoltage_status // Live register view
);
  import status_bank_pkg::*;

  logic [7:0] clk_cond_sync1_ff;
  logic [7:0] grp_cond_sync1_ff;
  logic [7:0] uv_cond_sync1_ff;
  logic [7:0] clk_cond_ff;
  logic [7:0] grp_cond_ff;
  logic [7:0] uv_cond_ff;
  logic [7:0] clk_flags_ff;
  logic [7:0] grp_flags_ff;
  logic [7:0] uv_flags_ff;
  logic [7:0] nxt_clk_flags;
  logic [7:0] nxt_grp_flags;
  logic [7:0] nxt_uv_flags;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  logic [7:0] clk_raw;
  logic [7:0] grp_raw;
  logic [7:0] uv_raw;

  // Place each monitor level at its register bit position
  always_comb begin
    clk_raw = RESET_VALUE;
    clk_raw[BIT_STEPUP_CLK] = clk_warn_in.stepup_clock_warning;
    clk_raw[BIT_LV_STEPDOWN_CLK] =
      clk_warn_in.lv_stepdown_clock_warning;
    clk_raw[BIT_WIDE_STEPDOWN_CLK] =
      clk_warn_in.wide_stepdown_clock_warning;
    clk_raw[BIT_SYNC_CLK] = clk_warn_in.sync_clock_warning;
    clk_raw[BIT_SOURCE_CLK] =
      clk_warn_in.switcher_source_clock_warning;
  end

  // Group result: errors high nibble, completion low nibble
  always_comb begin
    grp_raw = RESET_VALUE;
    grp_raw[GROUP_ERR_LSB +: 4] = group_in.group_error;
    grp_raw[GROUP_DONE_LSB +: 4] = group_in.group_complete;
  end

  // Undervoltage comparator self-test failures
  always_comb begin
    uv_raw = RESET_VALUE;
    uv_raw[BIT_INT_REG_UV] = uv_in.internal_regulator_uv_test_error;
    uv_raw[BIT_EXT_MON_TWO_UV] =
      uv_in.ext_monitor_two_uv_test_error;
    uv_raw[BIT_EXT_MON_ONE_UV] =
      uv_in.ext_monitor_one_uv_test_error;
    uv_raw[BIT_STEPUP_UV] = uv_in.stepup_uv_test_error;
    uv_raw[BIT_LV_STEPDOWN_UV] = uv_in.lv_stepdown_uv_test_error;
    uv_raw[BIT_WIDE_STEPDOWN_UV] =
      uv_in.wide_stepdown_uv_test_error;
  end

  // Two-stage synchronisers; monitors run in other domains
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_cond_sync1_ff <= RESET_VALUE;
      grp_cond_sync1_ff <= RESET_VALUE;
      uv_cond_sync1_ff <= RESET_VALUE;
      clk_cond_ff <= RESET_VALUE;
      grp_cond_ff <= RESET_VALUE;
      uv_cond_ff <= RESET_VALUE;
    end else begin
      clk_cond_sync1_ff <= clk_raw;
      grp_cond_sync1_ff <= grp_raw;
      uv_cond_sync1_ff <= uv_raw;
      clk_cond_ff <= clk_cond_sync1_ff;
      grp_cond_ff <= grp_cond_sync1_ff;
      uv_cond_ff <= uv_cond_sync1_ff;
    end
  end

  // Next flag value: a read drops only bits whose condition has gone;
  // the live condition is ORed last so a set wins over the clear.
  function automatic logic [7:0] next_flags(
    input logic [7:0] flags,
    input logic [7:0] cond,
    input logic [7:0] mask,
    input logic rd_hit
  );
    logic [7:0] kept;
    kept = rd_hit ? (flags & cond) : flags;
    return (kept | cond) & mask;
  endfunction : next_flags

  // Flag update; the write strobe has no path in here
  always_comb begin
    nxt_clk_flags = next_flags(clk_flags_ff, clk_cond_ff, CLOCK_WARN_MASK,
      rd_req.rd_strobe && rd_req.rd_sel == SEL_CLOCK_WARN);
    nxt_grp_flags = next_flags(grp_flags_ff, grp_cond_ff, GROUP_MASK,
      rd_req.rd_strobe && rd_req.rd_sel == SEL_GROUP);
    nxt_uv_flags = next_flags(uv_flags_ff, uv_cond_ff, UV_MASK,
      rd_req.rd_strobe && rd_req.rd_sel == SEL_UV);
  end

  // Sticky flag registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      clk_flags_ff <= RESET_VALUE;
      grp_flags_ff <= RESET_VALUE;
      uv_flags_ff <= RESET_VALUE;
    end else begin
      clk_flags_ff <= nxt_clk_flags;
      grp_flags_ff <= nxt_grp_flags;
      uv_flags_ff <= nxt_uv_flags;
    end
  end

  // Read data shows the value before the clear, so the host sees
  // the event it is acknowledging; a second read confirms it gone.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data_ff <= RESET_VALUE;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_req.rd_strobe;
      if (rd_req.rd_strobe) begin
        case (rd_req.rd_sel)
          SEL_CLOCK_WARN: rd_data_ff <= clk_flags_ff;
          SEL_GROUP: rd_data_ff <= grp_flags_ff;
          SEL_UV: rd_data_ff <= uv_flags_ff;
          default: rd_data_ff <= RESET_VALUE;
        endcase
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign clock_accuracy_warning_status = clk_flags_ff;
  assign selftest_group_status = grp_flags_ff;
  assign selftest_undervoltage_status = uv_flags_ff;

endmodule : safety_clock_selftest_status

`default_nettype wire

// [rtl/status_bank_pkg.sv]
package status_bank_pkg;

  // Register selects on the serial read path (index of the bank entry)
  localparam logic [1:0] SEL_CLOCK_WARN = 2'h0;
  localparam logic [1:0] SEL_GROUP = 2'h1;
  localparam logic [1:0] SEL_UV = 2'h2;
  localparam int NUM_REGS = 3;

  // Reset value of every register
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Bits that can latch; all other bits are reserved and read zero
  localparam logic [7:0] CLOCK_WARN_MASK = 8'h5e;
  localparam logic [7:0] GROUP_MASK = 8'hff;
  localparam logic [7:0] UV_MASK = 8'hbb;

  // Clock warning register field positions
  localparam int BIT_STEPUP_CLK = 6;
  localparam int BIT_LV_STEPDOWN_CLK = 4;
  localparam int BIT_WIDE_STEPDOWN_CLK = 3;
  localparam int BIT_SYNC_CLK = 2;
  localparam int BIT_SOURCE_CLK = 1;

  // Self-test group register fields
  localparam int GROUP_ERR_LSB = 4;
  localparam int GROUP_DONE_LSB = 0;

  // Undervoltage self-test register fields
  localparam int BIT_INT_REG_UV = 7;
  localparam int BIT_EXT_MON_TWO_UV = 5;
  localparam int BIT_EXT_MON_ONE_UV = 4;
  localparam int BIT_STEPUP_UV = 3;
  localparam int BIT_LV_STEPDOWN_UV = 1;
  localparam int BIT_WIDE_STEPDOWN_UV = 0;

  // Clock monitor warnings
  typedef struct packed {
    logic stepup_clock_warning;
    logic lv_stepdown_clock_warning;
    logic wide_stepdown_clock_warning;
    logic sync_clock_warning;
    logic switcher_source_clock_warning;
  } clock_warn_t;

  // Self-test group results, index 0 is group one
  typedef struct packed {
    logic [3:0] group_error;
    logic [3:0] group_complete;
  } group_result_t;

  // Undervoltage comparator self-test failures
  typedef struct packed {
    logic internal_regulator_uv_test_error;
    logic ext_monitor_two_uv_test_error;
    logic ext_monitor_one_uv_test_error;
    logic stepup_uv_test_error;
    logic lv_stepdown_uv_test_error;
    logic wide_stepdown_uv_test_error;
  } uv_result_t;

  // Serial read request from the frame decoder
  typedef struct packed {
    logic rd_strobe;
    logic [1:0] rd_sel;
  } read_req_t;

endpackage : status_bank_pkg

// [dv/status_bank_props.sv]
`timescale 1ns/100ps
`default_nettype none
module status_bank_props (
  input wire logic clk, // Clock
  input wire logic resetn, // Sync reset
  input wire status_bank_pkg::clock_warn_t clk_warn_in, // Monitors
  input wire status_bank_pkg::group_result_t group_in, // Groups
  input wire status_bank_pkg::uv_result_t uv_in, // UV tests
  input wire status_bank_pkg::read_req_t rd_req, // Read
  input wire logic wr_strobe, // Write
  input wire logic [7:0] rd_data, // Read data
  input wire logic rd_valid, // Data valid
  input wire logic [7:0] clock_accuracy_warning_status, // Clock reg
  input wire logic [7:0] selftest_group_status, // Group reg
  input wire logic [7:0] selftest_undervoltage_status // UV reg
);
  import status_bank_pkg::*;
  // One domain; sync reset masks every check
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_valid_pulse: assert property (rd_valid == $past(rd_req.rd_strobe))
    else $error("read valid not one cycle after strobe");
  chk_clock_readback: assert property (rd_req.rd_strobe &&
    rd_req.rd_sel == SEL_CLOCK_WARN |=>
    rd_data == $past(clock_accuracy_warning_status))
    else $error("clock register read data wrong");
  chk_unmapped_zero: assert property (rd_req.rd_strobe &&
    rd_req.rd_sel == 2'h3 |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_data_holds: assert property (!rd_req.rd_strobe |=> $stable(rd_data))
    else $error("read data changed without a read");
  chk_group_hold: assert property (!(rd_req.rd_strobe &&
    rd_req.rd_sel == SEL_GROUP) |=> (selftest_group_status &
    $past(selftest_group_status)) == $past(selftest_group_status))
    else $error("group flag dropped without a read");
  chk_reserved_zero: assert property (
    (clock_accuracy_warning_status & 8'ha1) == 8'h00 &&
    (selftest_undervoltage_status & 8'h44) == 8'h00)
    else $error("reserved bit set");
  chk_stepup_set: assert property (clk_warn_in.stepup_clock_warning
    |-> ##[1:4] clock_accuracy_warning_status[6])
    else $error("step-up warning not latched");
  chk_intreg_set: assert property (
    uv_in.internal_regulator_uv_test_error
    |-> ##[1:4] selftest_undervoltage_status[7])
    else $error("regulator test error not latched");
  chk_read_keeps_set: assert property (rd_req.rd_strobe &&
    rd_req.rd_sel == SEL_CLOCK_WARN &&
    $past(clk_warn_in.stepup_clock_warning, 2)
    |=> clock_accuracy_warning_status[6])
    else $error("read cleared a flag whose condition stands");
endmodule : status_bank_props
bind safety_clock_selftest_status status_bank_props u_props (.clk, .resetn,
  .clk_warn_in, .group_in, .uv_in, .rd_req, .wr_strobe, .rd_data, .rd_valid,
  .clock_accuracy_warning_status, .selftest_group_status,
  .selftest_undervoltage_status);
`default_nettype wire

// [dv/safety_clock_selftest_status_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module safety_clock_selftest_status_tb;
  import status_bank_pkg::*;
  logic clk = 0, resetn = 0, wr_strobe = 0, rd_valid;
  clock_warn_t clk_warn_in = '0;
  group_result_t group_in = '0;
  uv_result_t uv_in = '0;
  read_req_t rd_req = '0;
  logic [7:0] rd_data;
  int miscompares = 0, samples_checked = 0;
  // Monitor inputs, one at a time then all, and the register they give
  logic [4:0] cin [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h1f};
  logic [7:0] cexp [6] = '{8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h5e};
  logic [7:0] gpat [2] = '{8'ha5, 8'h5a};
  safety_clock_selftest_status dut (.clk, .resetn, .clk_warn_in, .group_in,
    .uv_in, .rd_req, .wr_strobe, .rd_data, .rd_valid,
    .clock_accuracy_warning_status(), .selftest_group_status(),
    .selftest_undervoltage_status());
  always #25 clk = ~clk;
  // Inputs only move on falling edges
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask : waitc
  // Strobe one cycle; answer is due exactly one cycle later
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    @(negedge clk);
    rd_req = {1'b1, s};
    @(negedge clk);
    rd_req.rd_strobe = 1'b0;
    samples_checked++;
    if ({rd_valid, rd_data} !== {1'b1, e}) begin
      miscompares++;
      $display("wrong value rd_data sel %0d exp %h got %h", s, e, rd_data);
    end
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence; write strobe held high from the first monitor test on to prove it is inert
  initial begin
    waitc(2);
    resetn = 1'b1;
    for (int s = 0; s < 4; s++) rd(s[1:0], 8'h00);
    wr_strobe = 1'b1;
    for (int i = 0; i < 6; i++) begin
      clk_warn_in = cin[i];
      waitc(4);
      clk_warn_in = '0;
      waitc(4);
      rd(SEL_CLOCK_WARN, cexp[i]);
      rd(SEL_CLOCK_WARN, 8'h00);
    end
    // Condition reaches the flag logic in the very cycle of a read
    clk_warn_in = 5'h10;
    waitc(1);
    rd(SEL_CLOCK_WARN, 8'h00);
    rd(SEL_CLOCK_WARN, 8'h40);
    clk_warn_in = '0;
    waitc(4);
    rd(SEL_CLOCK_WARN, 8'h40);
    rd(SEL_CLOCK_WARN, 8'h00);
    for (int i = 0; i < 2; i++) begin
      group_in = gpat[i];
      waitc(4);
      rd(SEL_GROUP, gpat[i]);
      rd(SEL_GROUP, gpat[i]);
      group_in = '0;
      waitc(4);
      rd(SEL_GROUP, gpat[i]);
      rd(SEL_GROUP, 8'h00);
    end
    uv_in = 6'h3f;
    waitc(4);
    uv_in = '0;
    rd(2'h3, 8'h00);
    waitc(4);
    rd(SEL_UV, 8'hbb);
    rd(SEL_UV, 8'h00);
    // Mid-run reset drops latched flags
    uv_in = 6'h3f;
    waitc(4);
    uv_in = '0;
    waitc(4);
    resetn = 1'b0;
    waitc(2);
    resetn = 1'b1;
    rd(SEL_UV, 8'h00);
    report_and_stop();
  end
  // Watchdog: the sequence needs about 150 cycles
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : safety_clock_selftest_status_tb
`default_nettype wire
